/* File: rps_defines.svh */
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// Register byte offsets
`define RPS_OFS_CTRL      4'h0
`define RPS_OFS_STATUS    4'h4
`define RPS_OFS_IFLAG     4'h8

// Control register fields
`define RPS_CTRL_EDGE_BIT 0
`define RPS_CTRL_DIV_LSB  1
`define RPS_CTRL_DIV_MSB  2

// Status register fields
`define RPS_ST_LOCK_BIT   0
`define RPS_ST_FAST_BIT   1
`define RPS_ST_QUIET_BIT  2
`define RPS_ST_HALT_BIT   3
`define RPS_ST_CNT_LSB    8
`define RPS_ST_CNT_MSB    15

// Counts and the x5 multiplier
`define RPS_LOCK_DONE_CNT 8'hff
`define RPS_WIND_CYCLES   4'ha
`define RPS_SIXTEENTH_CNT 4'hf
`define RPS_PLL_MULT      8'h05

`endif

/* File: rps_pkg.sv */
package rps_pkg;

    // Divider settings chosen by software
    typedef enum logic [1:0] {
        RPS_DIV_FULL,
        RPS_DIV_SIXTEENTH,
        RPS_DIV_HALT
    } rps_div_t;

    // Bus wind-down sequence
    typedef enum logic [1:0] {
        RPS_BUS_RUN,
        RPS_BUS_WIND,
        RPS_BUS_QUIET
    } rps_bus_t;

    // State of one interrupt conditioner
    typedef struct packed {
        logic [2:0] sync;     // Three-stage pin synchroniser
        logic       level;    // Agreed pin level
        logic       flag;     // Interrupt flag
    } rps_int_t;

    // State of the sequencer
    typedef struct packed {
        logic [2:0] refSync;
        logic       refLevel;
        logic [2:0] rstSync;
        logic       devRst;
        logic [2:0] mlSync;
        logic [2:0] mhSync;
        logic [1:0] clkMode;
        logic [7:0] lockCnt;
        logic       lockDone;
        logic       halfPh;
        logic       useFast;
        logic [7:0] perCnt;
        logic [7:0] perLast;
        logic [8:0] acc;
        rps_div_t   divMode;
        logic [3:0] divCnt;
        logic       edgeSel;
        logic       edgeArmed;
        rps_bus_t   busSt;
        logic [3:0] windCnt;
        logic       busQuiet;
        logic [2:0] flSync;   // Float pin synchroniser
        logic       floatLow; // Agreed float pin level
        logic       cpuTick;
        logic       halted;
        logic [31:0] rdData;
    } rps_seq_t;

endpackage : rps_pkg

/* File: rps_int_cond.sv */
`timescale 1ns/1ps
`include "rps_defines.svh"

module rps_int_cond (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Pin side
    input  wire logic intPinN,
    // Control
    input  wire logic edge_trigger_select,
    input  wire logic flagClr,
    // Results
    output logic      flag,
    output logic      levelLow
);

    // Whole state of the conditioner
    rps_pkg::rps_int_t st_r;
    rps_pkg::rps_int_t st_nxt;

    // Falling edge seen by the agreed level
    logic             fallPulse;
    // Request to set the flag this cycle
    logic             setReq;

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[1:0], intPinN};
        // Level changes only once stages two and three agree
        if (st_r.sync[1] == st_r.sync[2]) begin
            st_nxt.level = st_r.sync[2];
        end
        // Delay line decode: high last cycle, low now
        fallPulse = st_r.level && (st_r.sync[1] == st_r.sync[2]) && !st_r.sync[2];
        // Edge mode pulses once, level mode sets while low
        setReq = edge_trigger_select ? fallPulse : !st_r.level;
        // Set wins over a clear in the same cycle
        if (setReq) begin
            st_nxt.flag = 1'b1;
        end else if (flagClr) begin
            st_nxt.flag = 1'b0;
        end
    end

    // State register; synchroniser idles high (pins are active low)
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{sync: 3'h7, level: 1'b1, flag: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag     = st_r.flag;
    assign levelLow = !st_r.level;

endmodule : rps_int_cond

/* File: rps_sequencer.sv */
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "rps_defines.svh"

module rps_sequencer #(
    parameter int NUM_INT = 4      // Number of external interrupt pins
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               resetn,
    // Board pins
    input  wire logic               refClk,
    input  wire logic               devResetN,
    input  wire logic               outputFloatN,
    input  wire logic               clockModePinLow,
    input  wire logic               clockModePinHigh,
    input  wire logic [NUM_INT-1:0] intN,
    // Core side, same clock
    input  wire logic               busBusy,
    input  wire logic [NUM_INT-1:0] intClr,
    // Register port
    input  wire logic [3:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [31:0]             regRdata,
    // Clock, bus and interrupt results
    output logic                    cpuTick,
    output logic                    busQuiet,
    output logic                    busOeN,
    output logic                    clkHalted,
    output logic                    lockDone,
    output logic [NUM_INT-1:0]      intFlag
);

    // Elaboration check on the pin count
    if (NUM_INT < 1 || NUM_INT > 16) begin : g_chk
        $error("NUM_INT must lie between 1 and 16");
    end

    // Whole sequencer state
    rps_pkg::rps_seq_t st_r;
    rps_pkg::rps_seq_t st_nxt;

    // Conditioner results
    logic [NUM_INT-1:0] flagVec;
    logic [NUM_INT-1:0] lowVec;
    // Software and core clear requests per flag
    logic [NUM_INT-1:0] clrVec;
    // Pin float flag, asynchronously set
    logic               float_r;

    // Decoded register writes and pin events
    logic               wrCtrl;
    logic               wrFlag;
    logic               refRise;
    logic               srcTick;
    logic               rstFall;
    logic               anyLow;

    assign wrCtrl = regWr && (regAddr == `RPS_OFS_CTRL);
    assign wrFlag = regWr && (regAddr == `RPS_OFS_IFLAG);
    assign clrVec = intClr | (wrFlag ? regWdata[NUM_INT-1:0] : '0);
    assign anyLow = |lowVec;

    // One conditioner per interrupt pin
    for (genvar i = 0; i < NUM_INT; i++) begin : g_int
        rps_int_cond u_cond (
            .mclk     (mclk),
            .resetn   (resetn),
            .intPinN  (intN[i]),
            .edge_trigger_select (st_r.edgeSel && st_r.edgeArmed),
            .flagClr  (clrVec[i]),
            .flag     (flagVec[i]),
            .levelLow (lowVec[i])
        );
    end

    // Next state of the sequencer
    always_comb begin
        st_nxt = st_r;
        refRise = 1'b0;
        srcTick = 1'b0;
        rstFall = 1'b0;
        st_nxt.cpuTick = 1'b0;

        // Pin synchronisers, accepted once stages two and three agree
        st_nxt.refSync = {st_r.refSync[1:0], refClk};
        st_nxt.rstSync = {st_r.rstSync[1:0], !devResetN};
        st_nxt.mlSync  = {st_r.mlSync[1:0], clockModePinLow};
        st_nxt.mhSync  = {st_r.mhSync[1:0], clockModePinHigh};
        st_nxt.flSync  = {st_r.flSync[1:0], !outputFloatN};
        if (st_r.refSync[1] == st_r.refSync[2]) begin
            st_nxt.refLevel = st_r.refSync[2];
            refRise = st_r.refSync[2] && !st_r.refLevel;
        end
        if (st_r.rstSync[1] == st_r.rstSync[2]) begin
            st_nxt.devRst = st_r.rstSync[2];
            rstFall = st_r.rstSync[2] && !st_r.devRst;
        end
        if (st_r.mlSync[1] == st_r.mlSync[2]) begin
            st_nxt.clkMode[0] = st_r.mlSync[2];
        end
        if (st_r.mhSync[1] == st_r.mhSync[2]) begin
            st_nxt.clkMode[1] = st_r.mhSync[2];
        end
        if (st_r.flSync[1] == st_r.flSync[2]) begin
            st_nxt.floatLow = st_r.flSync[2];
        end

        // Lock counter advances on reference edges only
        // Holds while reset is low or the reference stands
        if (refRise && !st_r.devRst && !st_r.lockDone) begin
            st_nxt.lockCnt = st_r.lockCnt + 8'h01;
            if (st_r.lockCnt == `RPS_LOCK_DONE_CNT) begin
                st_nxt.lockDone = 1'b1;
            end
        end

        // Reference period measure for the x5 synthesis
        if (refRise) begin
            st_nxt.perLast = st_r.perCnt;
            st_nxt.perCnt  = 8'h01;
            st_nxt.halfPh  = !st_r.halfPh;
        end else if (st_r.perCnt != 8'hff) begin
            st_nxt.perCnt = st_r.perCnt + 8'h01;
        end

        // Switch to x5 only at a half-rate boundary, no short pulse
        if (refRise && st_r.halfPh) begin
            st_nxt.useFast = st_r.lockDone;
        end

        // Source tick by the clock mode pins
        st_nxt.acc = '0; // No stale residue on x5 entry
        case (st_r.clkMode)
            2'b00: srcTick = refRise;                        // Bypass, ratio 1
            2'b01: srcTick = refRise;                        // Ratio 1
            2'b10: srcTick = refRise && st_r.halfPh;         // Ratio 1/2
            2'b11: begin
                if (st_r.useFast) begin
                    // Five ticks per reference period on average
                    // Residue carries over reference edges: five per period
                    if ({1'b0, st_r.acc[7:0]} + {1'b0, `RPS_PLL_MULT}
                                 >= {1'b0, st_r.perLast}) begin
                        srcTick = 1'b1;
                        st_nxt.acc = {1'b0, st_r.acc[7:0]} + {1'b0, `RPS_PLL_MULT}
                                     - {1'b0, st_r.perLast};
                    end else begin
                        st_nxt.acc = st_r.acc + {1'b0, `RPS_PLL_MULT};
                    end
                end else begin
                    // Half the reference until lock is done
                    srcTick = refRise && st_r.halfPh;
                end
            end
            default: srcTick = refRise;
        endcase

        // Software control register
        if (wrCtrl) begin
            st_nxt.edgeSel   = regWdata[`RPS_CTRL_EDGE_BIT];
            // Edge detection armed only by software after reset
            st_nxt.edgeArmed = 1'b1;
            case (regWdata[`RPS_CTRL_DIV_MSB:`RPS_CTRL_DIV_LSB])
                2'b01:   st_nxt.divMode = rps_pkg::RPS_DIV_SIXTEENTH;
                2'b10:   st_nxt.divMode = rps_pkg::RPS_DIV_HALT;
                default: st_nxt.divMode = rps_pkg::RPS_DIV_FULL;
            endcase
        end

        // Halt left on reset or a low interrupt level
        if (st_r.divMode == rps_pkg::RPS_DIV_HALT && (st_r.devRst || anyLow)) begin
            st_nxt.divMode = rps_pkg::RPS_DIV_FULL;
        end

        // Reset fall clears divider mode and edge arming, and the divider count unless a sixteenth-mode tick lands in the same cycle
        if (rstFall) begin
            st_nxt.divMode   = rps_pkg::RPS_DIV_FULL;
            st_nxt.divCnt    = '0;
            st_nxt.edgeArmed = 1'b0;
        end

        // Divider on the source tick
        case (st_r.divMode)
            rps_pkg::RPS_DIV_FULL: begin
                st_nxt.cpuTick = srcTick;
                st_nxt.halted  = 1'b0;
            end
            rps_pkg::RPS_DIV_SIXTEENTH: begin
                st_nxt.halted = 1'b0;
                if (srcTick) begin
                    st_nxt.divCnt  = st_r.divCnt + 4'h1;
                    st_nxt.cpuTick = (st_r.divCnt == `RPS_SIXTEENTH_CNT);
                end
            end
            rps_pkg::RPS_DIV_HALT: begin
                st_nxt.halted = 1'b1;                        // Clock stopped
            end
            default: begin
                st_nxt.divMode = rps_pkg::RPS_DIV_FULL;
            end
        endcase

        // Bus wind-down on reset
        case (st_r.busSt)
            rps_pkg::RPS_BUS_RUN: begin
                st_nxt.busQuiet = 1'b0;
                if (st_r.devRst && st_r.floatLow) begin
                    // Float with reset: quiet at once
                    st_nxt.busSt    = rps_pkg::RPS_BUS_QUIET;
                    st_nxt.busQuiet = 1'b1;
                end else if (st_r.devRst) begin
                    st_nxt.busSt   = rps_pkg::RPS_BUS_WIND;
                    st_nxt.windCnt = '0;
                end
            end
            rps_pkg::RPS_BUS_WIND: begin
                // Finish the access, at most ten CPU cycles
                if (!busBusy || st_r.floatLow ||
                    (st_r.cpuTick && st_r.windCnt == `RPS_WIND_CYCLES - 4'h1)) begin
                    st_nxt.busSt    = rps_pkg::RPS_BUS_QUIET;
                    st_nxt.busQuiet = 1'b1;
                end else if (st_r.cpuTick) begin
                    st_nxt.windCnt = st_r.windCnt + 4'h1;
                end
            end
            rps_pkg::RPS_BUS_QUIET: begin
                st_nxt.busQuiet = 1'b1;
                if (!st_r.devRst) begin
                    st_nxt.busSt    = rps_pkg::RPS_BUS_RUN;
                    st_nxt.busQuiet = 1'b0;
                end
            end
            default: begin
                st_nxt.busSt = rps_pkg::RPS_BUS_QUIET;
            end
        endcase

        // Read data, one cycle after the strobe
        st_nxt.rdData = '0;
        if (regRd) begin
            case (regAddr)
                `RPS_OFS_CTRL: begin
                    st_nxt.rdData[`RPS_CTRL_EDGE_BIT] = st_r.edgeSel;
                    st_nxt.rdData[`RPS_CTRL_DIV_MSB:`RPS_CTRL_DIV_LSB] = st_r.divMode;
                end
                `RPS_OFS_STATUS: begin
                    st_nxt.rdData[`RPS_ST_LOCK_BIT]  = st_r.lockDone;
                    st_nxt.rdData[`RPS_ST_FAST_BIT]  = st_r.useFast;
                    st_nxt.rdData[`RPS_ST_QUIET_BIT] = st_r.busQuiet;
                    st_nxt.rdData[`RPS_ST_HALT_BIT]  = st_r.halted;
                    st_nxt.rdData[`RPS_ST_CNT_MSB:`RPS_ST_CNT_LSB] = st_r.lockCnt;
                end
                `RPS_OFS_IFLAG: begin
                    st_nxt.rdData[NUM_INT-1:0] = flagVec;
                end
                default: begin
                    st_nxt.rdData = '0;                      // Unmapped reads zero
                end
            endcase
        end
    end

    // Sequencer state register
    // The lock counter survives device resets; only power-on clears it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r           <= '0;
            st_r.refSync   <= 3'h0;
            st_r.rstSync   <= 3'h7;
            st_r.devRst    <= 1'b1; // Held until the pin is seen high
            st_r.busSt     <= rps_pkg::RPS_BUS_QUIET;
            st_r.busQuiet  <= 1'b1;
            st_r.perLast   <= 8'hff;
            st_r.divMode   <= rps_pkg::RPS_DIV_FULL;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output enable: float pin forces high with no clock needed
    // Float also wins over reset wind-down
    always_ff @(posedge mclk or negedge resetn or negedge outputFloatN) begin
        if (!resetn) begin
            float_r <= 1'b1;
        end else if (!outputFloatN) begin
            float_r <= 1'b1;
        end else begin
            float_r <= st_nxt.busQuiet;
        end
    end

    // Interrupt flags straight from the conditioner flops
    assign intFlag   = flagVec;
    assign regRdata  = st_r.rdData;
    assign cpuTick   = st_r.cpuTick;
    assign busQuiet  = st_r.busQuiet;
    assign busOeN    = float_r;
    assign clkHalted = st_r.halted;
    assign lockDone  = st_r.lockDone;

endmodule : rps_sequencer

/* File: rps_board_model.sv */
`timescale 1ns/1ps
module rps_board_model #(
    parameter int REF_HALF = 97 // Reference half period in ns, unrelated to mclk
) (
    // Bench commands
    input  wire logic mclk,
    input  wire logic rstCmd,
    input  wire logic floatCmd,
    // Board pins
    output logic      refClk,
    output logic      devResetN,
    output logic      outputFloatN,
    output int        refCount
);
    int floatGap; // Cycles since the float pin was lifted

    // Free-running oscillator; a real crystal never pauses
    initial begin
        refClk = 1'b0;
        refCount = 0;
        devResetN = 1'b0;
        outputFloatN = 1'b1;
        floatGap = 100;
        forever #(REF_HALF) refClk = ~refClk;
    end

    // Rise counter the bench uses to time its windows
    always @(posedge refClk) refCount <= refCount + 1;

    // Reset and float pins move just after mclk edges
    always @(posedge mclk) begin
        outputFloatN <= !floatCmd;
        floatGap <= !outputFloatN ? 0 : floatGap + 1;
        if (refCount < 256 || rstCmd) begin
            devResetN <= 1'b0;
        end else if (floatGap >= 64) begin // Margin over ten slow cycles
            devResetN <= 1'b1;
        end
    end
endmodule : rps_board_model

/* File: rps_sequencer_chk.sv */
`timescale 1ns/1ps
module rps_sequencer_chk #(
    parameter int NUM_INT = 4 // Interrupt pin count
) (
    // Clock, reset and pins
    input wire logic               mclk,
    input wire logic               resetn,
    input wire logic               refClk,
    input wire logic               devResetN,
    input wire logic               outputFloatN,
    input wire logic               clockModePinLow,
    input wire logic               clockModePinHigh,
    input wire logic [NUM_INT-1:0] intN,
    // Core side and register port
    input wire logic               busBusy,
    input wire logic [NUM_INT-1:0] intClr,
    input wire logic [3:0]         regAddr,
    input wire logic [31:0]        regWdata,
    input wire logic               regWr,
    input wire logic               regRd,
    // Results
    input wire logic [31:0]        regRdata,
    input wire logic               cpuTick,
    input wire logic               busQuiet,
    input wire logic               busOeN,
    input wire logic               clkHalted,
    input wire logic               lockDone,
    input wire logic [NUM_INT-1:0] intFlag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic edgeOn_r; // Edge mode armed; a pin reset disarms it
    // Follows control writes so interrupt checks know the mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            edgeOn_r <= 1'b0;
        end else if (!devResetN) begin
            edgeOn_r <= 1'b0;
        end else if (regWr && regAddr == 4'h0) begin
            edgeOn_r <= regWdata[0];
        end
    end

    sequence rstFall;
        devResetN ##1 !devResetN;
    endsequence

    chk_float_oe: assert property (!outputFloatN |-> busOeN)
        else $error("bus driven while float pin low");
    chk_quiet_oe: assert property (busQuiet |-> busOeN)
        else $error("bus driven while quiet");
    chk_float_fast: assert property ((!devResetN && !outputFloatN) [*8] |-> busQuiet)
        else $error("float reset not immediate");
    chk_wind_idle: assert property ((!devResetN && !busBusy) [*8] |-> busQuiet)
        else $error("idle bus not quiet in reset");
    chk_wind_bound: assert property (rstFall |-> ##[1:800] (busQuiet || devResetN))
        else $error("wind-down too long");
    chk_lock_sticky: assert property (lockDone |=> lockDone)
        else $error("lock flag dropped");
    chk_lock_hold: assert property (!devResetN [*8] |-> $stable(lockDone))
        else $error("lock moved during reset");
    chk_halt_quiet: assert property (clkHalted [*2] |-> !cpuTick)
        else $error("tick while halted");
    chk_halt_wake: assert property ((intN != '1) [*6] |-> ##[0:4] !clkHalted)
        else $error("halt not left on low pin");
    chk_rst_unhalt: assert property (!devResetN [*6] |-> !clkHalted)
        else $error("halt kept through reset");
    chk_tick_runt: assert property (cpuTick |=> !cpuTick)
        else $error("runt tick");

    // Interrupt relations, one set per pin
    for (genvar g = 0; g < NUM_INT; g++) begin : g_pin
        sequence lowEdge;
            (edgeOn_r && devResetN && !intN[g]) [*8];
        endsequence
        chk_level_set: assert property ((!edgeOn_r && devResetN && !intN[g]) [*6] |-> intFlag[g])
            else $error("level flag missing");
        chk_edge_once: assert property (lowEdge ##1 (edgeOn_r && !intN[g] && intClr[g]) |=> !intFlag[g])
            else $error("edge flag set twice");
    end
endmodule : rps_sequencer_chk

bind rps_sequencer rps_sequencer_chk #(.NUM_INT(NUM_INT)) u_rps_chk (
    .mclk(mclk), .resetn(resetn), .refClk(refClk), .devResetN(devResetN),
    .outputFloatN(outputFloatN), .clockModePinLow(clockModePinLow),
    .clockModePinHigh(clockModePinHigh), .intN(intN), .busBusy(busBusy), .intClr(intClr),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cpuTick(cpuTick), .busQuiet(busQuiet), .busOeN(busOeN),
    .clkHalted(clkHalted), .lockDone(lockDone), .intFlag(intFlag)
);

/* File: rps_sequencer_tb_top.sv */
`timescale 1ns/1ps
module rps_sequencer_tb_top;
    localparam int NI = 4; // Interrupt pins
    logic          mclk, resetn, rstCmd, floatCmd;       // Clock and commands
    logic [1:0]    clkPins;                              // Mode pins {high, low}
    logic [NI-1:0] intN, intClr, intFlag;                // Interrupt side
    logic          busBusy, regWr, regRd;                // Core side strobes
    logic [3:0]    regAddr;                              // Register address
    logic [31:0]   regWdata, regRdata, rd;               // Register data
    logic          cpuTick, busQuiet, busOeN, clkHalted; // Results
    logic          lockDone, refClk, devResetN, outputFloatN;
    int            refCount, errTotal, compares, n, i;

    rps_board_model u_rps_board_model (.mclk(mclk), .rstCmd(rstCmd), .floatCmd(floatCmd),
        .refClk(refClk), .devResetN(devResetN), .outputFloatN(outputFloatN),
        .refCount(refCount));
    rps_sequencer #(.NUM_INT(NI)) u_rps_sequencer (.mclk(mclk), .resetn(resetn),
        .refClk(refClk), .devResetN(devResetN), .outputFloatN(outputFloatN),
        .clockModePinLow(clkPins[0]), .clockModePinHigh(clkPins[1]), .intN(intN),
        .busBusy(busBusy), .intClr(intClr), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuTick(cpuTick),
        .busQuiet(busQuiet), .busOeN(busOeN), .clkHalted(clkHalted),
        .lockDone(lockDone), .intFlag(intFlag));

    // 100 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Verdict, reached from the end of the run or a timeout
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            errTotal++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    // Counts may slip up to tol steps at window edges
    task automatic near(input int got, input int want, input int tol);
        check({31'h0, got >= want - tol && got <= want + tol}, 32'h1);
    endtask : near

    // Bench model of tick rate: per reference periods, mode, lock, divider
    function automatic int expTicks(input int per, input logic [1:0] pins, input int lk,
                                    input int dv);
        int t;
        t = (pins == 2'b10 || (pins == 2'b11 && lk == 0)) ? per / 2 : pins == 2'b11 ? per * 5 : per;
        return dv == 1 ? t / 16 : dv == 2 ? 0 : t;
    endfunction : expTicks

    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : regWrite

    // Read data stands only in the cycle after the strobe
    task automatic rdChk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(posedge mclk);
        check(regRdata & m, e);
    endtask : rdChk

    // Bounded wait: 0 lock, 1 quiet, 2 halted, 3 pin reset released
    task automatic waitFor(input int sel, input logic val, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(posedge mclk);
            if ((sel == 0 ? lockDone : sel == 1 ? busQuiet : sel == 2 ? clkHalted : devResetN) === val)
                return;
        end
        errTotal++;
        $display("BAD %0t wait %0d ran out", $time, sel);
        conclude();
    endtask : waitFor

    // Ticks over whole reference periods
    task automatic ticks(input int per, output int cnt);
        int r0;
        cnt = 0;
        r0 = refCount;
        for (int k = 0; k < 9000 && refCount == r0; k++) @(posedge mclk);
        r0 = refCount;
        for (int k = 0; k < 90000 && refCount < r0 + per; k++) begin
            @(posedge mclk);
            if (cpuTick === 1'b1) cnt++;
        end
    endtask : ticks

    // Pin level held several cycles
    task automatic pin(input int p, input logic v, input int hold);
        intN[p] <= v;
        repeat (hold) @(posedge mclk);
    endtask : pin

    task automatic clr(input int p);
        intClr[p] <= 1'b1;
        @(posedge mclk);
        intClr <= '0;
        @(posedge mclk);
    endtask : clr

    initial begin
        {resetn, floatCmd, busBusy, regWr, regRd} = '0;
        {rstCmd, clkPins, intN, intClr, regAddr, regWdata} = {1'b1, 2'b11, {NI{1'b1}}, 40'h0};
        {errTotal, compares} = '0;
        rd = $urandom(63);
        repeat (10) @(posedge mclk);
        check({busQuiet, busOeN, lockDone, intFlag}, {3'b110, 4'h0});
        resetn <= 1'b1;
        for (i = 0; i < 8000 && refCount < 256; i++) @(posedge mclk);
        check(refCount, 256);
        rdChk(4'h4, 32'hff01, 32'h0);
        $display("test hold done");
        rstCmd <= 1'b0;
        waitFor(3, 1'b1, 300);
        i = refCount;
        ticks(8, n);
        near(n, expTicks(8, 2'b11, 0, 0), 1);
        waitFor(0, 1'b1, 8000);
        near(refCount - i, 256, 3);
        repeat (60) @(posedge mclk); // Fast bit needs a half-phase edge
        rdChk(4'h4, 32'h3, 32'h3);
        for (i = 0; i < 4; i++) begin
            clkPins <= 2'(i);
            ticks(2, n);
            ticks(8, n);
            near(n, expTicks(8, 2'(i), 1, 0), 2);
        end
        $display("test lock done");
        busBusy <= 1'b1;
        rstCmd <= 1'b1;
        repeat (6) @(posedge mclk);
        check(busQuiet, 1'b0);
        waitFor(1, 1'b1, 80);
        check(lockDone, 1'b1);
        {busBusy, rstCmd} <= 2'b00;
        waitFor(3, 1'b1, 200);
        ticks(8, n);
        near(n, expTicks(8, 2'b11, 1, 0), 2);
        check({busQuiet, busOeN}, 2'b00);
        floatCmd <= 1'b1;
        @(posedge mclk);
        #1 check(busOeN, 1'b1);
        @(posedge mclk);
        {busBusy, rstCmd} <= 2'b11;
        repeat (10) @(posedge mclk);
        check(busQuiet, 1'b1);
        {busBusy, rstCmd, floatCmd} <= 3'b000;
        waitFor(3, 1'b1, 200);
        $display("test bus done");
        i = $urandom_range(NI - 1);
        pin(i, 1'b0, 2);
        check(intFlag[i], 1'b0);
        repeat (4) @(posedge mclk);
        clr(i);
        check(intFlag[i], 1'b1);
        pin(i, 1'b1, 5);
        clr(i);
        check(intFlag[i], 1'b0);
        pin(i, 1'b0, 3);
        pin(i, 1'b1, 6);
        check(intFlag[i], 1'b1);
        regWrite(4'h8, 32'h1 << i);
        rdChk(4'h8, 32'hf, 32'h0);
        regWrite(4'h0, ($urandom & 32'hfffffff8) | 32'h1);
        pin(i, 1'b0, 12);
        check(intFlag[i], 1'b1);
        clr(i);
        repeat (6) @(posedge mclk);
        check(intFlag[i], 1'b0);
        pin(i, 1'b1, 3);
        pin(i, 1'b0, 6);
        check(intFlag[i], 1'b1);
        pin(i, 1'b1, 3);
        clr(i);
        rstCmd <= 1'b1;
        waitFor(1, 1'b1, 80);
        rstCmd <= 1'b0;
        waitFor(3, 1'b1, 200);
        repeat (5) @(posedge mclk);
        pin(i, 1'b0, 8);
        clr(i);
        check(intFlag[i], 1'b1);
        pin(i, 1'b1, 5);
        clr(i);
        $display("test interrupt done");
        regWrite(4'h0, 32'h2);
        ticks(32, n);
        near(n, expTicks(32, 2'b11, 1, 1), 1);
        regWrite(4'h0, 32'h4);
        waitFor(2, 1'b1, 10);
        ticks(4, n);
        check(n, expTicks(4, 2'b11, 1, 2));
        pin(i, 1'b0, 3);
        waitFor(2, 1'b0, 10);
        pin(i, 1'b1, 5);
        clr(i);
        regWrite(4'h0, 32'h0);
        rdChk(4'hc, 32'hffffffff, 32'h0);
        regWrite(4'h4, 32'hffffffff);
        rdChk(4'h4, 32'hf, 32'h3);
        $display("test divider done");
        conclude();
    end
endmodule : rps_sequencer_tb_top
